// file: dv/io_line_control_tb.sv
// Self-checking bench of the I/O line control block
`timescale 1ns/1ps
`default_nettype none
module io_line_control_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1; // Clock enable, dropped once to check the freeze
  logic trig_wait = 1'b0;
  logic expo_active = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] lvl = 2'h0; // Steady levels of the sources
  logic [1:0] glitch = 2'h0;
  logic [7:0] glen = 8'h00;
  wire logic [1:0] in_pin;
  wire logic [1:0] out_drive;
  wire logic acq_start;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  logic [31:0] rd; // Last read data
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0; // Cycle count at falling edges
  int acq_cnt = 0;
  int acq_cyc = 0;

  always #12.5 core_clk = ~core_clk;

  io_line_control uut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .in_pin(in_pin),
    .trig_wait(trig_wait), .expo_active(expo_active), .out_drive(out_drive),
    .acq_start(acq_start), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp));
  io_line_far far (.core_clk(core_clk), .lvl(lvl), .glitch(glitch), .glen(glen),
    .in_pin(in_pin));

  // Pulses are counted at the falling edge, where the output has settled
  always @(negedge core_clk)
  begin
    cyc <= cyc + 1;
    if (acq_start === 1'b1)
    begin
      acq_cnt <= acq_cnt + 1;
      acq_cyc <= cyc;
    end
  end

  // ****************************************************************
  // Tasks and functions
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // One single AHB transfer; hreadyout is looked at 1 ns after an edge, which is
  // the value the next edge samples, so no race with the design's registers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    logic r;
    int n;
    n = 0;
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do
    begin
      #1 r = hreadyout;
      @(posedge core_clk);
      n++;
    end
    while (r !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      #1 r = hreadyout;
      rd = hrdata;
      @(posedge core_clk);
      n++;
    end
    while (r !== 1'b1 && n < 64);
    check(32'(hresp), 32'h0, "bus response");
    if (n >= 64)
      check(32'h1, 32'h0, "bus hang");
  endtask : bus

  // Expected drive of an output from its source, inverter and user value
  function automatic logic exp_drive(logic [1:0] src, logic inv, logic uv);
    logic v;
    v = (src == io_line_pkg::SRC_TRIG_WAIT) ? trig_wait :
        (src == io_line_pkg::SRC_EXPO) ? expo_active :
        (src == io_line_pkg::SRC_USER) ? uv : 1'b0; // Spare code gives 0 ahead of the inverter
    return v ^ inv;
  endfunction : exp_drive

  task automatic give_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    logic [1:0] s_a [2];
    logic i_a [2];
    logic u_a [2];
    logic e0, e1, inv;
    int k, j, t;
    s_a = '{2'h2, 2'h2};
    i_a = '{1'b0, 1'b0};
    u_a = '{1'b0, 1'b0};
    void'($urandom(32'h23ad));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    // Reset values through the selector
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, io_line_pkg::REG_SEL, 32'(k));
      bus(1'b0, (k < 2) ? io_line_pkg::REG_DEB_US : io_line_pkg::REG_OUT_SRC, 32'h0);
      check(rd, (k < 2) ? 32'(io_line_pkg::DEB_DEF_US) : 32'h2, "reset value");
    end
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // Every output source on both outputs, random inverter and levels
    for (k = 0; k < 32; k++)
    begin
      j = (k / 4) % 2;
      s_a[j] = 2'(k % 4);
      i_a[j] = 1'($urandom);
      u_a[j] = 1'($urandom);
      bus(1'b1, io_line_pkg::REG_SEL, 32'(j + 2));
      bus(1'b1, io_line_pkg::REG_OUT_SRC, 32'(s_a[j]));
      bus(1'b1, io_line_pkg::REG_INVERT, 32'(i_a[j]));
      bus(1'b1, io_line_pkg::REG_USER_VAL, 32'(u_a[j]));
      trig_wait <= 1'($urandom);
      expo_active <= 1'($urandom);
      repeat (3) @(posedge core_clk);
      e0 = exp_drive(s_a[0], i_a[0], u_a[0]);
      e1 = exp_drive(s_a[1], i_a[1], u_a[1]);
      check(32'(out_drive), {30'h0, e1, e0}, "drive");
      bus(1'b0, io_line_pkg::REG_LINE_STAT, 32'h0);
      check(rd, 32'(j ? e1 : e0), "line status");
      bus(1'b0, io_line_pkg::REG_STAT_ALL, 32'h0);
      check(rd, {28'h0, e1, e0, 2'h0}, "status all");
    end
    // Clock enable low freezes the drive although its source moves
    bus(1'b1, io_line_pkg::REG_SEL, 32'h2);
    bus(1'b1, io_line_pkg::REG_INVERT, 32'h0);
    bus(1'b1, io_line_pkg::REG_OUT_SRC, 32'(io_line_pkg::SRC_EXPO));
    expo_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b0;
    expo_active <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(32'(out_drive[0]), 32'h0, "frozen drive");
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(32'(out_drive[0]), 32'h1, "drive after enable");
    // Each input as trigger: glitch refused, held level accepted after the delay
    for (k = 0; k < 2; k++)
    begin
      inv = 1'($urandom);
      bus(1'b1, io_line_pkg::REG_SEL, 32'(k));
      bus(1'b1, io_line_pkg::REG_INVERT, 32'(inv));
      bus(1'b1, io_line_pkg::REG_DEB_US, 32'h1); // 40 cycles, above the glitch
      bus(1'b1, io_line_pkg::REG_TRIG_CFG, 32'({k[0], 1'b1}));
      lvl[k] <= inv;
      repeat (80) @(posedge core_clk);
      t = acq_cnt;
      glen <= 8'h14;
      glitch[k] <= 1'b1;
      @(posedge core_clk);
      glitch[k] <= 1'b0;
      repeat (80) @(posedge core_clk);
      check(32'(acq_cnt - t), 32'h0, "glitch passed");
      t = cyc;
      j = acq_cnt;
      lvl[k] <= ~inv;
      repeat (60) @(posedge core_clk);
      check(32'(acq_cnt - j), 32'h1, "trigger count");
      check(32'((acq_cyc - t) inside {[40:46]}), 32'h1, "trigger delay");
      bus(1'b0, io_line_pkg::REG_LINE_STAT, 32'h0);
      check(rd, 32'h1, "input status");
      bus(1'b0, io_line_pkg::REG_STAT_ALL, 32'h0);
      check(32'(rd[k]), 32'h1, "input status all");
      lvl[k] <= inv;
      repeat (60) @(posedge core_clk);
      bus(1'b0, io_line_pkg::REG_LINE_STAT, 32'h0);
      check(rd, 32'h0, "input low");
      check(32'(acq_cnt - j), 32'h1, "falling edge trigger");
    end
    give_verdict();
  end

  // Watchdog, well beyond the 1400 or so cycles the tests take
  initial
  begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule : io_line_control_tb
`default_nettype wire

// file: dv/io_line_far.sv
// Model of the external trigger sources that drive the two input lines
`timescale 1ns/1ps
`default_nettype none
module io_line_far (
  input wire logic core_clk,
  input wire logic [1:0] lvl,
  input wire logic [1:0] glitch,
  input wire logic [7:0] glen,
  output logic [1:0] in_pin
);
  // ****************************************************************
  // Sources hold their lines actively at all times
  // ****************************************************************
  logic [7:0] left_q [2]; // Remaining glitch cycles of each line
  initial left_q = '{8'h00, 8'h00};

  // A glitch request flips the line for glen cycles, then the level returns
  always @(posedge core_clk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (glitch[k])
        left_q[k] <= glen;
      else if (left_q[k] != 8'h00)
        left_q[k] <= left_q[k] - 8'h01;
    end
  end

  // Lines are never left floating, so no unknown reaches the synchroniser
  assign in_pin[0] = (left_q[0] != 8'h00) ? ~lvl[0] : lvl[0];
  assign in_pin[1] = (left_q[1] != 8'h00) ? ~lvl[1] : lvl[1];
endmodule : io_line_far
`default_nettype wire

// file: rtl/io_line_control.sv
// I/O line control: input debounce and trigger, output source selection, AHB-Lite registers
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module io_line_control (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [1:0] in_pin,
  input wire logic trig_wait,
  input wire logic expo_active,
  output logic [1:0] out_drive,
  output logic acq_start,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Cycle count of a debounce time; zero is treated as one cycle
  function automatic logic [21:0] deb_limit(input logic [15:0] us);
    logic [21:0] lim;
    lim = 22'(22'(us) * 22'(io_line_pkg::CYC_PER_US));
    if (lim == 22'h0)
      lim = 22'h1;
    return lim;
  endfunction : deb_limit

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q; // Release shift register
  logic rst_n;            // Synchronised reset, active low

  // Two flops so that release never lands near an edge
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // State
  // ****************************************************************
  io_line_pkg::state_t s_q; // Registered state
  io_line_pkg::state_t s_d; // Next state
  logic [1:0] raw_lvl;      // Inverted synchronised pins
  logic [1:0] src_lvl;      // Selected output source before inverter
  logic [3:0] line_all;     // Level of every line
  logic addr_take;          // Address phase accepted
  logic [31:0] rd_mux;      // Read data before its flop

  // Output source mux; user value sits before the inverter
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      case (s_q.out_src[i])
        io_line_pkg::SRC_TRIG_WAIT: src_lvl[i] = trig_wait;
        io_line_pkg::SRC_EXPO: src_lvl[i] = expo_active;
        io_line_pkg::SRC_USER: src_lvl[i] = s_q.user_val[i];
        default: src_lvl[i] = 1'b0;                          // Unused code: off
      endcase
    end
  end

  // Inverter ahead of the debouncer, so filtering sees the logic view
  assign raw_lvl = s_q.pin_s2 ^ s_q.in_inv;

  // Line levels: inputs as logic sees them, outputs as driven
  assign line_all = {s_q.out_ctrl, s_q.in_stable};
  assign addr_take = hsel && htrans[1] && hready;

  // Read data of the address held in the data phase
  always_comb
  begin
    rd_mux = 32'h0;
    case (s_q.ph_addr)
      io_line_pkg::REG_SEL: rd_mux = {30'h0, s_q.sel};
      io_line_pkg::REG_INVERT:
        rd_mux = {31'h0, s_q.sel[1] ? s_q.out_inv[s_q.sel[0]] : s_q.in_inv[s_q.sel[0]]};
      io_line_pkg::REG_DEB_US:
        rd_mux = s_q.sel[1] ? 32'h0 : {16'h0, s_q.deb_us[s_q.sel[0]]};
      io_line_pkg::REG_OUT_SRC:
        rd_mux = s_q.sel[1] ? {30'h0, s_q.out_src[s_q.sel[0]]} : 32'h0;
      io_line_pkg::REG_USER_VAL:
        rd_mux = s_q.sel[1] ? {31'h0, s_q.user_val[s_q.sel[0]]} : 32'h0;
      io_line_pkg::REG_LINE_STAT: rd_mux = {31'h0, line_all[s_q.sel]};
      io_line_pkg::REG_STAT_ALL: rd_mux = {28'h0, line_all};
      io_line_pkg::REG_TRIG_CFG: rd_mux = {30'h0, s_q.trig_line, s_q.trig_en};
      default: rd_mux = 32'h0; // Unmapped reads as zero
    endcase
  end

  // Next-state logic of the whole block
  always_comb
  begin
    s_d = s_q;
    // Pin synchronisers
    s_d.pin_s1 = in_pin;
    s_d.pin_s2 = s_q.pin_s1;
    // Debouncers: count hold time of a differing level
    for (int i = 0; i < 2; i++)
    begin
      if (raw_lvl[i] == s_q.in_stable[i])
        s_d.deb_cnt[i] = 22'h0; // Glitch ended early, discard it
      else if (22'(s_q.deb_cnt[i] + 22'h1) >= deb_limit(s_q.deb_us[i]))
      begin
        s_d.in_stable[i] = raw_lvl[i]; // Held long enough, pass on late
        s_d.deb_cnt[i] = 22'h0;
      end
      else
        s_d.deb_cnt[i] = 22'(s_q.deb_cnt[i] + 22'h1);
    end
    // Trigger on rising edge of the chosen filtered input
    s_d.acq_trig = s_q.trig_en && s_d.in_stable[s_q.trig_line]
      && !s_q.in_stable[s_q.trig_line];
    // Output drive, 1 turns the transistor on
    s_d.out_ctrl = src_lvl ^ s_q.out_inv;
    // Bus data phase
    if (s_q.ph_valid && s_q.ph_write)
    begin
      s_d.ph_valid = 1'b0;
      case (s_q.ph_addr)
        io_line_pkg::REG_SEL: s_d.sel = hwdata[1:0];
        io_line_pkg::REG_INVERT:
          if (s_q.sel[1])
            s_d.out_inv[s_q.sel[0]] = hwdata[0];
          else
            s_d.in_inv[s_q.sel[0]] = hwdata[0];
        io_line_pkg::REG_DEB_US:
          if (!s_q.sel[1])
            s_d.deb_us[s_q.sel[0]] = hwdata[15:0];
        io_line_pkg::REG_OUT_SRC:
          if (s_q.sel[1])
            s_d.out_src[s_q.sel[0]] = hwdata[1:0];
        io_line_pkg::REG_USER_VAL:
          if (s_q.sel[1])
            s_d.user_val[s_q.sel[0]] = hwdata[0];
        io_line_pkg::REG_TRIG_CFG:
        begin
          s_d.trig_en = hwdata[io_line_pkg::TRIG_EN_BIT];
          s_d.trig_line = hwdata[io_line_pkg::TRIG_LINE_BIT];
        end
        default: s_d.ph_valid = 1'b0; // Read-only and unmapped writes ignored
      endcase
    end
    else if (s_q.ph_valid && !s_q.rd_done)
    begin
      // First read cycle: load the data flop, hold the bus
      s_d.hrdata = rd_mux;
      s_d.rd_done = 1'b1;
    end
    else if (s_q.ph_valid)
    begin
      // Second read cycle: data stands, phase completes
      s_d.ph_valid = 1'b0;
      s_d.rd_done = 1'b0;
    end
    // A new address phase only when the bus is ready
    if (addr_take && hreadyout)
    begin
      s_d.ph_valid = 1'b1;
      s_d.ph_write = hwrite;
      s_d.ph_addr = {haddr[7:2], 2'h0};
      s_d.rd_done = 1'b0;
    end
  end

  // State flop; clock enable freezes everything
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.deb_us <= {io_line_pkg::DEB_DEF_US, io_line_pkg::DEB_DEF_US};
      s_q.out_src <= {io_line_pkg::SRC_USER, io_line_pkg::SRC_USER};
    end
    else if (clk_en)
      s_q <= s_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reads wait one cycle so write-then-read never returns stale data
  assign hreadyout = !(s_q.ph_valid && !s_q.ph_write && !s_q.rd_done);
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign out_drive = s_q.out_ctrl;
  assign acq_start = s_q.acq_trig;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Every property below runs on the core clock and sleeps during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic [21:0] lim0; // Debounce limit of input line 1
  logic [21:0] lim1; // Debounce limit of input line 2
  assign lim0 = deb_limit(s_q.deb_us[0]);
  assign lim1 = deb_limit(s_q.deb_us[1]);

  // ****************************************************************
  // Output lines
  // ****************************************************************

  // Registered drive equals the chosen source through the inverter
  AST_OUT_DRIVE: assert property (
    clk_en |=> out_drive == $past(src_lvl ^ s_q.out_inv))
    else $error("Output drive does not match source and inverter");

  // Inverted user output shows the complement of the written value
  AST_OUT_INV: assert property (
    (clk_en && s_q.out_inv[0] && s_q.out_src[0] == io_line_pkg::SRC_USER)
    |=> out_drive[0] == !$past(s_q.user_val[0]))
    else $error("Inverted user output not complemented");

  // Plain user output follows the written value
  AST_USER_VAL: assert property (
    (clk_en && !s_q.out_inv[1] && s_q.out_src[1] == io_line_pkg::SRC_USER)
    |=> out_drive[1] == $past(s_q.user_val[1]))
    else $error("User output does not follow software value");

  // Exposure source on line 1 reaches the drive one cycle later
  AST_EXPO_SRC: assert property (
    (clk_en && s_q.out_src[0] == io_line_pkg::SRC_EXPO)
    |=> out_drive[0] == ($past(expo_active) ^ $past(s_q.out_inv[0])))
    else $error("Exposure source not routed to output");

  // ****************************************************************
  // Input lines
  // ****************************************************************

  // A level held shorter than the debounce time leaves line 1 alone
  AST_DEB_REJECT: assert property (
    (clk_en && raw_lvl[0] != s_q.in_stable[0] && 22'(s_q.deb_cnt[0] + 22'h1) < lim0)
    |=> $stable(s_q.in_stable[0]))
    else $error("Input accepted before debounce time");

  // Same on line 2, which counts against its own time setting
  AST_DEB_REJECT2: assert property (
    (clk_en && raw_lvl[1] != s_q.in_stable[1] && 22'(s_q.deb_cnt[1] + 22'h1) < lim1)
    |=> $stable(s_q.in_stable[1]))
    else $error("Input 2 accepted before its debounce time");

  // An accepted change on line 1 has waited out the full count
  AST_DEB_DELAY: assert property (
    $changed(s_q.in_stable[0])
    |-> $past(22'(s_q.deb_cnt[0] + 22'h1)) >= $past(lim0))
    else $error("Accepted edge without full debounce delay");

  // Trigger only from a rising edge of the input chosen before the edge
  AST_TRIG_EDGE: assert property (
    (acq_start && $past(clk_en)) |-> $past(s_q.trig_en)
    && !$past(s_q.in_stable[s_q.trig_line]) && s_q.in_stable[$past(s_q.trig_line)])
    else $error("Trigger without rising edge on its source");

  // Trigger is a single-cycle pulse
  AST_TRIG_PULSE: assert property (
    (acq_start && clk_en) |=> !acq_start)
    else $error("Trigger pulse longer than one cycle");

  // A rising edge on enabled line 1 always starts acquisition
  AST_TRIG_FIRE: assert property (
    ($rose(s_q.in_stable[0]) && $past(s_q.trig_en) && !$past(s_q.trig_line))
    |-> acq_start)
    else $error("Rising edge on trigger input gave no trigger");

  // ****************************************************************
  // Register bus
  // ****************************************************************

  // Debounce write with the selector on input 2 lands in input 2
  AST_SEL_WRITE: assert property (
    (clk_en && s_q.ph_valid && s_q.ph_write && s_q.ph_addr == io_line_pkg::REG_DEB_US
    && s_q.sel == io_line_pkg::SEL_IN2) |=> s_q.deb_us[1] == $past(hwdata[15:0]))
    else $error("Debounce write missed the selected line");

  // Status-all read returns every line level
  AST_STAT_ALL: assert property (
    (clk_en && s_q.ph_valid && !s_q.ph_write && !s_q.rd_done
    && s_q.ph_addr == io_line_pkg::REG_STAT_ALL) |=> hrdata == {28'h0, $past(line_all)})
    else $error("Status-all word wrong");

  // Line status read returns the level of the selected line
  AST_LINE_STAT: assert property (
    (clk_en && s_q.ph_valid && !s_q.ph_write && !s_q.rd_done
    && s_q.ph_addr == io_line_pkg::REG_LINE_STAT) |=> hrdata[0] == $past(line_all[s_q.sel]))
    else $error("Line status wrong");

  // A read waits exactly one cycle
  AST_READ_DONE: assert property (
    (clk_en && !hreadyout) ##1 clk_en |-> hreadyout)
    else $error("Read wait longer than one cycle");

  // Read data stands until the next read loads it
  AST_RD_STANDS: assert property (
    (!clk_en || hreadyout) |=> $stable(hrdata))
    else $error("Read data changed outside a read");

  // Every transfer ends with an OKAY response
  AST_RESP_OKAY: assert property (
    !hresp)
    else $error("Error response on the bus");

  // ****************************************************************
  // Scenarios worth seeing
  // ****************************************************************
  COV_TRIGGER: cover property (acq_start);
  COV_TRIG_IN2: cover property (acq_start && s_q.trig_line);
  COV_USER_OUT: cover property (s_q.out_src[0] == io_line_pkg::SRC_USER && out_drive[0]);
  COV_GLITCH: cover property (raw_lvl[0] != s_q.in_stable[0] ##1
    raw_lvl[0] == s_q.in_stable[0]);
  COV_DEB_PASS: cover property ($rose(s_q.in_stable[0]));

endmodule : io_line_control

`default_nettype wire

// file: rtl/io_line_pkg.sv
// Package with register map, field codes, timing constants and state type of the I/O lines
package io_line_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 25000;      // Core clock period, 40 MHz
  localparam int US_PS = 1000000;            // One microsecond in picoseconds
  localparam int CYC_PER_US = US_PS / CLK_PERIOD_PS; // Cycles per microsecond
  localparam logic [15:0] DEB_DEF_US = 16'h000a; // Debounce time after reset, 10 us

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] REG_SEL = 8'h00;       // Line selector
  localparam logic [7:0] REG_INVERT = 8'h04;    // Inverter of the selected line
  localparam logic [7:0] REG_DEB_US = 8'h08;    // Debounce time of selected input, us
  localparam logic [7:0] REG_OUT_SRC = 8'h0c;   // Source of selected output
  localparam logic [7:0] REG_USER_VAL = 8'h10;  // User value of selected output
  localparam logic [7:0] REG_LINE_STAT = 8'h14; // State of the selected line
  localparam logic [7:0] REG_STAT_ALL = 8'h18;  // State of all lines
  localparam logic [7:0] REG_TRIG_CFG = 8'h1c;  // Trigger enable and input choice

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [1:0] SEL_IN1 = 2'h0;        // Selector codes
  localparam logic [1:0] SEL_IN2 = 2'h1;
  localparam logic [1:0] SEL_OUT1 = 2'h2;
  localparam logic [1:0] SEL_OUT2 = 2'h3;
  localparam logic [1:0] SRC_TRIG_WAIT = 2'h0;  // Output source codes
  localparam logic [1:0] SRC_EXPO = 2'h1;
  localparam logic [1:0] SRC_USER = 2'h2;
  localparam int TRIG_EN_BIT = 0;               // Trigger config bit positions
  localparam int TRIG_LINE_BIT = 1;
  localparam int STAT_IN_LSB = 0;               // Status-all bit of input line 1
  localparam int STAT_OUT_LSB = 2;              // Status-all bit of output line 1

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic [1:0] pin_s1;          // First sync stage of input pins
    logic [1:0] pin_s2;          // Second sync stage
    logic [1:0] in_stable;       // Debounced, inverted input levels
    logic [1:0][21:0] deb_cnt;   // Hold-time counters
    logic [1:0][15:0] deb_us;    // Debounce times in microseconds
    logic [1:0] in_inv;          // Input inverters
    logic [1:0] out_inv;         // Output inverters
    logic [1:0][1:0] out_src;    // Output sources
    logic [1:0] user_val;        // Software output values
    logic [1:0] sel;             // Line selector
    logic trig_en;               // Hardware trigger enable
    logic trig_line;             // Input chosen as trigger source
    logic acq_trig;              // Trigger pulse
    logic [1:0] out_ctrl;        // Transistor drive
    logic ph_valid;              // Pending data phase
    logic ph_write;              // Pending phase is a write
    logic rd_done;               // Read data loaded
    logic [7:0] ph_addr;         // Pending address
    logic [31:0] hrdata;         // Read data
  } state_t;

endpackage : io_line_pkg
